// *** flash_host_map.svh ***
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// Register byte offsets on the Avalon slave
`define REG_CTRL 5'h00
`define REG_ADDR 5'h04
`define REG_DATA 5'h08
`define REG_CMD 5'h0C
`define REG_STATUS 5'h10
`define REG_RDATA 5'h14

// Field positions
`define CTRL_BYTE_BIT 0
`define CTRL_RESET_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_WINDOW_BIT 1
`define STAT_REJECT_BIT 2
`define STAT_RESET_BIT 3
`define STAT_READY_BIT 4

// Unlock addresses, word and byte mode
`define UNLOCK1_WORD 20'h00555
`define UNLOCK2_WORD 20'h002AA
`define UNLOCK1_BYTE 20'h00AAA
`define UNLOCK2_BYTE 20'h00555

// Command data codes
`define CODE_UNLOCK1 16'h00AA
`define CODE_UNLOCK2 16'h0055
`define CODE_ERASE_SETUP 16'h0080
`define CODE_SECTOR_ERASE 16'h0030
`define CODE_PROGRAM 16'h00A0
`define CODE_EXIT_SETUP 16'h0090
`define CODE_EXIT_FINAL 16'h0000
`define CODE_SUSPEND 16'h00B0
`define CODE_RESUME 16'h0030
`define CODE_RESET 16'h00F0

// Last step index of each sequence
`define LAST_ERASE 3'h5
`define LAST_PROGRAM 3'h3
`define LAST_EXIT 3'h3
`define LAST_SINGLE 3'h0

// Timing
`define CLK_MHZ 25
`define WINDOW_US 50
`define WINDOW_CYC (`WINDOW_US * `CLK_MHZ)
`define WINDOW_MARGIN 11'h010
`define CYC_SETUP 4'h2
`define CYC_PULSE 4'h5
`define CYC_HOLD 4'h2

`endif

// *** flash_host_pkg.sv ***
package flash_host_pkg;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_READ = 4'b0001,
		OP_PROGRAM = 4'b0010,
		OP_ERASE = 4'b0011,
		OP_ADD_SECTOR = 4'b0100,
		OP_SUSPEND = 4'b0101,
		OP_RESUME = 4'b0110,
		OP_RESET = 4'b0111,
		OP_EXIT_SECURED = 4'b1000
	} op_type;

	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00,
		CYC_SETUP = 2'b01,
		CYC_PULSE = 2'b10,
		CYC_HOLD = 2'b11
	} cyc_state_type;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ISSUE = 2'b01,
		SEQ_WAIT = 2'b10
	} seq_state_type;

	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} flash_out_type;

	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
		logic is_write;
	} cycle_req_type;

endpackage : flash_host_pkg

// *** flash_bus_cycle.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_map.svh"

module flash_bus_cycle (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic abort,
	input wire flash_host_pkg::cycle_req_type req,
	input wire logic [15:0] dq_in_sync,
	output var flash_host_pkg::flash_out_type pins,
	output var logic done,
	output var logic [15:0] rdata
);
	import flash_host_pkg::*;

	typedef struct packed {
		cyc_state_type st;
		logic [3:0] cnt;
		logic wr;
		flash_out_type pins;
		logic done;
		logic [15:0] rdata;
	} cyc_reg_type;

	cyc_reg_type q;
	cyc_reg_type n;

	always_comb begin
		n = q;
		n.done = 1'b0;
		case (q.st)
			CYC_IDLE: begin
				if (start && !abort) begin
					// Address stands before the strobe falls, so it is latched on that edge
					n.pins.addr = req.addr;
					n.pins.dq_out = req.data;
					n.pins.dq_oe = req.is_write;
					n.pins.ce_n = 1'b0;
					n.wr = req.is_write;
					n.cnt = `CYC_SETUP - 4'h1;
					n.st = CYC_SETUP;
				end
			end
			CYC_SETUP: begin
				if (q.cnt == 4'h0) begin
					n.pins.we_n = !q.wr;
					n.pins.oe_n = q.wr;
					n.cnt = `CYC_PULSE - 4'h1;
					n.st = CYC_PULSE;
				end else begin
					n.cnt = q.cnt - 4'h1;
				end
			end
			CYC_PULSE: begin
				if (q.cnt == 4'h0) begin
					n.rdata = dq_in_sync;
					n.pins.we_n = 1'b1;
					n.pins.oe_n = 1'b1;
					n.cnt = `CYC_HOLD - 4'h1;
					n.st = CYC_HOLD;
				end else begin
					n.cnt = q.cnt - 4'h1;
				end
			end
			CYC_HOLD: begin
				// Data kept driven past the rising strobe for the hold time
				if (q.cnt == 4'h0) begin
					n.pins.ce_n = 1'b1;
					n.pins.dq_oe = 1'b0;
					n.done = 1'b1;
					n.st = CYC_IDLE;
				end else begin
					n.cnt = q.cnt - 4'h1;
				end
			end
			default: n.st = CYC_IDLE;
		endcase
		if (abort) begin
			n.st = CYC_IDLE;
			n.pins.ce_n = 1'b1;
			n.pins.we_n = 1'b1;
			n.pins.oe_n = 1'b1;
			n.pins.dq_oe = 1'b0;
			n.done = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.pins.ce_n <= 1'b1;
			q.pins.we_n <= 1'b1;
			q.pins.oe_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign pins = q.pins;
	assign done = q.done;
	assign rdata = q.rdata;

	// Strobe pulse width is five cycles, matching the pulse count
	// An abort cuts the strobe short on purpose
	write_pulse_a: assert property (@(posedge clk) disable iff (reset || abort)
		($fell(q.pins.we_n) && !abort) |-> (!q.pins.we_n && !q.pins.ce_n)[*5] ##1 q.pins.we_n)
		else $error("write strobe width wrong");

endmodule : flash_bus_cycle
`default_nettype wire

// *** flash_host_ctrl.sv ***
// How it works
// - Sector erase: six writes ending sector/30.
// - Byte mode swaps unlock addresses to AAA/555.
// - Extra entries spaced under 50 us.
// - Erase writes go out without pause.
// - Other writes except suspend in window abort; host refuses them.
// - Hardware reset aborts; host then resequences.
// - Secured exit: unlock, unlock, 90, 00.
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_map.svh"

module flash_host_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output var logic [31:0] avs_readdata,
	output var logic avs_waitrequest,
	output var flash_host_pkg::flash_out_type flash,
	input wire logic [15:0] flash_dq_in,
	input wire logic ready_busy_n,
	output var logic flash_reset_n,
	output var logic flash_byte_n
);
	import flash_host_pkg::*;

	typedef struct packed {
		seq_state_type st;
		op_type op;
		logic [2:0] step;
		logic byte_mode;
		logic rst_req;
		logic [19:0] addr;
		logic [15:0] data;
		logic [15:0] rdata;
		logic [10:0] win_cnt;
		logic win_open;
		logic rejected;
		logic waitreq;
		logic [31:0] rd;
		logic start;
		cycle_req_type req;
		logic [15:0] dq_s1;
		logic [15:0] dq_s2;
		logic rb_s1;
		logic rb_s2;
	} ctrl_reg_type;

	ctrl_reg_type q;
	ctrl_reg_type n;
	logic cyc_done;
	logic [15:0] cyc_rdata;

	function automatic logic [2:0] last_step(input op_type op);
		case (op)
			OP_ERASE: last_step = `LAST_ERASE;
			OP_PROGRAM: last_step = `LAST_PROGRAM;
			OP_EXIT_SECURED: last_step = `LAST_EXIT;
			default: last_step = `LAST_SINGLE;
		endcase
	endfunction : last_step

	function automatic cycle_req_type step_req(input op_type op, input logic [2:0] idx,
			input logic bmode, input logic [19:0] a, input logic [15:0] d);
		logic [19:0] u1;
		logic [19:0] u2;
		logic [15:0] setup;
		u1 = bmode ? `UNLOCK1_BYTE : `UNLOCK1_WORD;
		u2 = bmode ? `UNLOCK2_BYTE : `UNLOCK2_WORD;
		setup = (op == OP_ERASE) ? `CODE_ERASE_SETUP :
			(op == OP_PROGRAM) ? `CODE_PROGRAM : `CODE_EXIT_SETUP;
		step_req = '{addr: 20'h00000, data: 16'h0000, is_write: 1'b1};
		if (idx != last_step(op)) begin
			case (idx)
				3'h0, 3'h3: step_req = '{addr: u1, data: `CODE_UNLOCK1, is_write: 1'b1};
				3'h1, 3'h4: step_req = '{addr: u2, data: `CODE_UNLOCK2, is_write: 1'b1};
				default: step_req = '{addr: u1, data: setup, is_write: 1'b1};
			endcase
		end else begin
			case (op)
				OP_ERASE, OP_ADD_SECTOR: step_req.addr = a;
				OP_PROGRAM, OP_READ: step_req.addr = a;
				default: step_req.addr = 20'h00000;
			endcase
			case (op)
				OP_ERASE, OP_ADD_SECTOR: step_req.data = `CODE_SECTOR_ERASE;
				OP_PROGRAM: step_req.data = d;
				OP_EXIT_SECURED: step_req.data = `CODE_EXIT_FINAL;
				OP_SUSPEND: step_req.data = `CODE_SUSPEND;
				OP_RESUME: step_req.data = `CODE_RESUME;
				OP_RESET: step_req.data = `CODE_RESET;
				default: step_req.data = 16'h0000;
			endcase
			step_req.is_write = (op != OP_READ);
		end
	endfunction : step_req

	logic [31:0] wmask;
	logic [31:0] wd;
	logic reg_wr;
	logic cmd_ok;
	logic reject_set;
	op_type new_op;

	always_comb begin
		n = q;
		n.start = 1'b0;
		n.dq_s1 = flash_dq_in;
		n.dq_s2 = q.dq_s1;
		n.rb_s1 = ready_busy_n;
		n.rb_s2 = q.rb_s1;
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wd = avs_writedata & wmask;
		// Write takes effect on the edge where waitrequest is seen low
		reg_wr = avs_write && !q.waitreq;
		new_op = op_type'(wd[3:0]);
		reject_set = 1'b0;
		cmd_ok = 1'b0;

		// Window timer; host-side copy of the acceptance window
		if (q.win_open) begin
			if (q.win_cnt == 11'h000) begin
				n.win_open = 1'b0;
			end else begin
				n.win_cnt = q.win_cnt - 11'h001;
			end
		end

		case (q.st)
			SEQ_ISSUE: begin
				n.start = 1'b1;
				n.req = step_req(q.op, q.step, q.byte_mode, q.addr, q.data);
				n.st = SEQ_WAIT;
			end
			SEQ_WAIT: begin
				if (cyc_done) begin
					if (q.op == OP_READ) begin
						n.rdata = cyc_rdata;
					end
					if (q.step == last_step(q.op)) begin
						n.st = SEQ_IDLE;
						if (q.op == OP_ERASE || q.op == OP_ADD_SECTOR) begin
							n.win_cnt = 11'(`WINDOW_CYC);
							n.win_open = 1'b1;
						end
						if (q.op == OP_SUSPEND) begin
							n.win_open = 1'b0;
						end
					end else begin
						// Next erase write follows at once, keeping the window tight
						n.step = 3'(q.step + 3'h1);
						n.st = SEQ_ISSUE;
					end
				end
			end
			default: n.st = SEQ_IDLE;
		endcase

		if (reg_wr) begin
			case (avs_address)
				`REG_CTRL: begin
					n.byte_mode = wd[`CTRL_BYTE_BIT];
					n.rst_req = wd[`CTRL_RESET_BIT];
				end
				`REG_ADDR: n.addr = wd[19:0];
				`REG_DATA: n.data = wd[15:0];
				`REG_CMD: begin
					if (q.st != SEQ_IDLE || q.rst_req || new_op == OP_NONE) begin
						cmd_ok = 1'b0;
					end else if (new_op == OP_ADD_SECTOR) begin
						// Late entries refused: the device may already be erasing
						cmd_ok = q.win_open && (q.win_cnt > `WINDOW_MARGIN);
					end else if (q.win_open) begin
						cmd_ok = (new_op == OP_SUSPEND);
					end else begin
						cmd_ok = (new_op <= OP_EXIT_SECURED);
					end
					reject_set = !cmd_ok;
					if (cmd_ok) begin
						n.op = new_op;
						n.step = 3'h0;
						n.st = SEQ_ISSUE;
					end
				end
				default: ;
			endcase
		end

		// Set wins over the write-one clear
		n.rejected = (q.rejected && !(reg_wr && avs_address == `REG_STATUS &&
			wd[`STAT_REJECT_BIT])) || reject_set;

		if (q.rst_req) begin
			n.st = SEQ_IDLE;
			n.win_open = 1'b0;
		end

		n.waitreq = !((avs_read || avs_write) && q.waitreq);
		case (avs_address)
			`REG_CTRL: n.rd = {30'h0, q.rst_req, q.byte_mode};
			`REG_ADDR: n.rd = {12'h000, q.addr};
			`REG_DATA: n.rd = {16'h0000, q.data};
			`REG_CMD: n.rd = {28'h0000000, q.op};
			`REG_STATUS: n.rd = {27'h0, q.rb_s2, q.rst_req, q.rejected, q.win_open,
				q.st != SEQ_IDLE};
			`REG_RDATA: n.rd = {16'h0000, q.rdata};
			default: n.rd = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.waitreq <= 1'b1;
			// Busy pin idles high; a zero here would read as busy after reset
			q.rb_s1 <= 1'b1;
			q.rb_s2 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	flash_bus_cycle cycle_unit (
		.clk(clk),
		.reset(reset),
		.start(q.start),
		.abort(q.rst_req),
		.req(q.req),
		.dq_in_sync(q.dq_s2),
		.pins(flash),
		.done(cyc_done),
		.rdata(cyc_rdata)
	);

	assign avs_readdata = q.rd;
	assign avs_waitrequest = q.waitreq;
	assign flash_reset_n = !q.rst_req;
	assign flash_byte_n = !q.byte_mode;

	erase_final_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.op == OP_ERASE && q.step == `LAST_ERASE) |->
		(q.req.addr == q.addr && q.req.data == `CODE_SECTOR_ERASE && q.req.is_write))
		else $error("erase final write wrong");

	erase_setup_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.op == OP_ERASE && q.step == 3'h2) |->
		q.req.data == `CODE_ERASE_SETUP)
		else $error("erase setup code wrong");

	unlock_addr_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.step == 3'h1 && q.op inside {OP_ERASE, OP_PROGRAM, OP_EXIT_SECURED}) |->
		q.req.addr == (q.byte_mode ? `UNLOCK2_BYTE : `UNLOCK2_WORD))
		else $error("second unlock address wrong");

	entry_in_window_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.op == OP_ADD_SECTOR) |-> q.win_open)
		else $error("sector entry outside window");

	erase_burst_a: assert property (@(posedge clk) disable iff (reset)
		(cyc_done && q.op == OP_ERASE && q.step != `LAST_ERASE && !q.rst_req) |->
		##2 q.start)
		else $error("erase writes not back to back");

	window_guard_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.win_open) |-> q.op inside {OP_ADD_SECTOR, OP_SUSPEND})
		else $error("foreign write inside window");

	reset_abort_a: assert property (@(posedge clk) disable iff (reset)
		q.rst_req |-> (!flash_reset_n ##1 (q.st == SEQ_IDLE && !q.win_open && flash.ce_n)))
		else $error("reset did not abort");

	exit_seq_a: assert property (@(posedge clk) disable iff (reset)
		(q.start && q.op == OP_EXIT_SECURED && q.step == `LAST_EXIT) |->
		(q.req.data == `CODE_EXIT_FINAL && $past(q.req.data, 9) == `CODE_EXIT_SETUP))
		else $error("secured exit sequence wrong");

endmodule : flash_host_ctrl
`default_nettype wire

// *** flash_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_map.svh"

module flash_dev_model #(
	parameter real WIN_NS = 50000.0,
	parameter real ERASE_NS = 100000.0,
	parameter real PROG_NS = 4000.0,
	// Arbitrary value, not the code of any real part
	parameter logic [15:0] ID_CODE = 16'h00C7
) (
	input wire flash_host_pkg::flash_out_type pins,
	input wire logic reset_n,
	input wire logic byte_n,
	output wire logic [15:0] dq_in,
	output wire logic ready_busy_n
);
	import flash_host_pkg::*;
	typedef enum logic [2:0] {M_IDLE, M_WINDOW, M_ERASING, M_SUSP, M_SPROG} dev_mode_type;
	dev_mode_type mode_q = M_IDLE;
	logic [179:0] hist_q = '0;
	logic [35:0] log_q [$];
	logic [31:0] eset_q = 32'h0;
	logic [19:0] alat_q = 20'h0;
	logic [15:0] rv_q = 16'h0;
	logic tog_q = 1'b0;
	logic auto_q = 1'b0;
	realtime t_q = 0.0;
	wire logic [19:0] u1;
	wire logic [19:0] u2;
	wire logic busy;
	assign u1 = byte_n ? `UNLOCK1_WORD : `UNLOCK1_BYTE;
	assign u2 = byte_n ? `UNLOCK2_WORD : `UNLOCK2_BYTE;
	assign busy = mode_q == M_WINDOW || mode_q == M_ERASING || mode_q == M_SPROG;
	assign ready_busy_n = busy ? 1'b0 : 1'b1;
	// No pull-up on data: a released bus shows the inverse of the last value
	assign dq_in = (!pins.ce_n && !pins.oe_n) ? rv_q : ~rv_q;

	// Coarse polling of the internal timers is fine against 50 us spans
	always #100 begin
		if (mode_q == M_WINDOW && $realtime - t_q >= WIN_NS) begin
			mode_q = M_ERASING;
			t_q = $realtime;
		end else if (mode_q == M_ERASING && $realtime - t_q >= ERASE_NS) begin
			mode_q = M_IDLE;
			eset_q = 32'h0;
		end else if (mode_q == M_SPROG && $realtime - t_q >= PROG_NS) begin
			mode_q = M_SUSP;
		end
	end

	always @(negedge reset_n) begin
		mode_q = M_IDLE;
		eset_q = 32'h0;
		auto_q = 1'b0;
	end

	always @(negedge pins.we_n) if (!pins.ce_n) alat_q = pins.addr;

	always @(posedge pins.we_n) begin
		if (!pins.ce_n && pins.dq_oe && reset_n) begin
			log_q.push_back({alat_q, pins.dq_out});
			case (mode_q)
			M_WINDOW: if (pins.dq_out == 16'h0030) begin
				eset_q[alat_q[19:15]] = 1'b1;
				t_q = $realtime;
			end else begin
				mode_q = (pins.dq_out == 16'h00B0) ? M_SUSP : M_IDLE;
			end
			M_ERASING: if (pins.dq_out == 16'h00B0) mode_q = M_SUSP;
			M_SUSP: if (auto_q) begin
				if (pins.dq_out == 16'h00F0) auto_q = 1'b0;
			end else if (hist_q[107:0] == {u1, 16'h00AA, u2, 16'h0055, u1, 16'h00A0}) begin
				mode_q = M_SPROG;
				t_q = $realtime;
			end else if (pins.dq_out == 16'h0030) begin
				mode_q = M_ERASING;
				t_q = $realtime;
			end else if (pins.dq_out == 16'h0090 && alat_q == u1 &&
					hist_q[71:0] == {u1, 16'h00AA, u2, 16'h0055}) begin
				auto_q = 1'b1;
			end
			default: if (pins.dq_out == 16'h0030 && hist_q == {u1, 16'h00AA, u2, 16'h0055,
					u1, 16'h0080, u1, 16'h00AA, u2, 16'h0055}) begin
				mode_q = M_WINDOW;
				eset_q[alat_q[19:15]] = 1'b1;
				t_q = $realtime;
			end
			endcase
			hist_q = {hist_q[143:0], alat_q, pins.dq_out};
		end
	end

	always @(negedge pins.oe_n) begin
		if (busy) tog_q = ~tog_q;
		if (auto_q)
			rv_q = ID_CODE;
		else if (busy || (mode_q == M_SUSP && eset_q[pins.addr[19:15]]))
			rv_q = {8'h00, mode_q == M_SUSP, tog_q, 2'b00, mode_q == M_ERASING, 3'b000};
		else
			rv_q = pins.addr[15:0] ^ 16'hA5C3;
	end
endmodule : flash_dev_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_map.svh"

module tb;
	import flash_host_pkg::*;
	localparam logic [35:0] all_m = 36'hFFFFFFFFF;
	localparam logic [35:0] data_m = 36'h00000FFFF;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	flash_out_type flash;
	wire logic [15:0] flash_dq_in;
	wire logic ready_busy_n;
	logic flash_reset_n;
	logic flash_byte_n;
	int err_count = 0;
	int n_compared = 0;

	always #20 clk = ~clk;

	flash_host_ctrl uut (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.flash(flash), .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n),
		.flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n));

	flash_dev_model #(.ERASE_NS(100000.0)) dev (.pins(flash), .reset_n(flash_reset_n),
		.byte_n(flash_byte_n), .dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));

	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		// No limit of its own: the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		bus(a, 1'b0, 32'h0, q);
	endtask : rd

	task automatic settle;
		logic [31:0] s;
		do begin
			rd(`REG_STATUS, s);
		end while (s[`STAT_BUSY_BIT] !== 1'b0);
	endtask : settle

	task automatic cmd(input logic [19:0] a, input logic [3:0] op);
		wr(`REG_ADDR, {12'h0, a});
		wr(`REG_CMD, {28'h0, op});
		settle;
	endtask : cmd

	// Empty log yields all ones so that a missing write never matches
	task automatic popw(input logic [35:0] m, input logic [35:0] e);
		logic [35:0] v;
		v = all_m;
		if (dev.log_q.size() > 0) v = dev.log_q.pop_front();
		chk(v & m, e);
	endtask : popw

	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		conclude;
	end

	initial begin
		logic [31:0] s;
		logic [31:0] r;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(`REG_STATUS, s);
		chk(s, 32'h10);
		rd(5'h18, s);
		chk(s, 32'h0);
		$display("test 1 done");
		cmd(20'h10000, 4'h3);
		popw(all_m, {`UNLOCK1_WORD, `CODE_UNLOCK1});
		popw(all_m, {`UNLOCK2_WORD, `CODE_UNLOCK2});
		popw(all_m, {`UNLOCK1_WORD, `CODE_ERASE_SETUP});
		popw(all_m, {`UNLOCK1_WORD, `CODE_UNLOCK1});
		popw(all_m, {`UNLOCK2_WORD, `CODE_UNLOCK2});
		popw(all_m, {20'h10000, `CODE_SECTOR_ERASE});
		rd(`REG_STATUS, s);
		chk(s, 32'h2);
		cmd(20'h20000, 4'h4);
		popw(all_m, {20'h20000, `CODE_SECTOR_ERASE});
		wr(`REG_CMD, 32'h7);
		rd(`REG_STATUS, s);
		chk(s, 32'h6);
		chk(dev.log_q.size(), 0);
		wr(`REG_STATUS, 32'h4);
		$display("test 2 done");
		cmd(20'h0, 4'h5);
		popw(data_m, {20'h0, `CODE_SUSPEND});
		rd(`REG_STATUS, s);
		chk(s, 32'h10);
		cmd(20'h10004, 4'h1);
		rd(`REG_RDATA, r);
		chk(r & 32'h80, 32'h80);
		cmd(20'h30000, 4'h1);
		rd(`REG_RDATA, r);
		chk(r, 32'hA5C3);
		wr(`REG_DATA, 32'h1234);
		cmd(20'h30000, 4'h2);
		popw(data_m, {20'h0, `CODE_UNLOCK1});
		popw(data_m, {20'h0, `CODE_UNLOCK2});
		popw(data_m, {20'h0, `CODE_PROGRAM});
		popw(all_m, {20'h30000, 16'h1234});
		rd(`REG_STATUS, s);
		chk(s & 32'h10, 32'h0);
		repeat (120) @(posedge clk);
		cmd(20'h30000, 4'h1);
		rd(`REG_RDATA, r);
		chk(r, 32'hA5C3);
		cmd(20'h0, 4'h8);
		popw(data_m, {20'h0, `CODE_UNLOCK1});
		popw(data_m, {20'h0, `CODE_UNLOCK2});
		popw(data_m, {20'h0, `CODE_EXIT_SETUP});
		popw(data_m, {20'h0, `CODE_EXIT_FINAL});
		cmd(20'h10000, 4'h1);
		rd(`REG_RDATA, r);
		chk(r, {16'h0000, dev.ID_CODE});
		cmd(20'h0, 4'h7);
		popw(data_m, {20'h0, `CODE_RESET});
		cmd(20'h10004, 4'h1);
		rd(`REG_RDATA, r);
		chk(r & 32'h80, 32'h80);
		$display("test 3 done");
		cmd(20'h0, 4'h6);
		popw(data_m, {20'h0, `CODE_RESUME});
		rd(`REG_STATUS, s);
		chk(s & 32'h10, 32'h0);
		cmd(20'h10000, 4'h1);
		rd(`REG_RDATA, r);
		cmd(20'h10000, 4'h1);
		rd(`REG_RDATA, s);
		chk({r[7], s[7], r[6] ^ s[6], r[3]}, 36'h3);
		wr(`REG_CTRL, 32'h2);
		settle;
		rd(`REG_STATUS, s);
		chk(s & 32'h18, 32'h18);
		chk(flash_reset_n, 1'b0);
		wr(`REG_CTRL, 32'h0);
		$display("test 4 done");
		wr(`REG_CTRL, 32'h1);
		// Pin settles after the edge that took the write
		@(posedge clk);
		chk(flash_byte_n, 1'b0);
		cmd(20'h0, 4'h8);
		popw(all_m, {`UNLOCK1_BYTE, `CODE_UNLOCK1});
		popw(all_m, {`UNLOCK2_BYTE, `CODE_UNLOCK2});
		popw(all_m, {`UNLOCK1_BYTE, `CODE_EXIT_SETUP});
		popw(all_m, {20'h0, `CODE_EXIT_FINAL});
		wr(`REG_CTRL, 32'h0);
		cmd(20'h0, 4'h7);
		popw(data_m, {20'h0, `CODE_RESET});
		$display("test 5 done");
		conclude;
	end
endmodule : tb
`default_nettype wire
